/* hw/ipcb_bridge.sv */
`timescale 1ns/1ps
module ipcb_bridge
	import ipcb_pkg::*;
(
	input  wire logic            clock,
	input  wire logic            rst,
	input  wire logic            ce,
	input  wire logic            vme_as_n,
	input  wire logic [1:0]      vme_ds_n,
	input  wire logic            vme_write_n,
	input  wire logic [5:0]      vme_am,
	input  wire logic [23:1]     vme_addr,
	input  wire logic [15:0]     vme_data_i,
	output logic      [15:0]     vme_data_o,
	output logic                 vme_data_oe,
	output logic                 vme_dtack_oe,
	output logic                 vme_berr_oe,
	output logic      [7:1]      vme_irq_oe,
	input  wire logic [5:0]      board_base_sel,
	output logic                 ip_clk,
	output logic                 ip_reset_n,
	output logic      [3:0]      ip_iosel_n,
	output logic      [3:0]      ip_idsel_n,
	output logic      [3:0]      ip_memsel_n,
	output logic                 ip_rw_n,
	output logic      [22:1]     ip_addr,
	output logic      [1:0]      ip_bs_n,
	input  wire logic [15:0]     ip_data_i,
	output logic      [15:0]     ip_data_o,
	output logic                 ip_data_oe,
	input  wire logic            ip_ack_n,
	input  wire logic [NREQ-1:0] ip_intreq_n,
	input  wire logic [3:0]      ip_error_n
);
	typedef enum {B_IDLE, B_MOD, B_ANS} ipcb_bus_e;
	localparam int SV_W = 59;

	ipcb_link_if link ();
	ipcb_bus_e     state_reg;
	logic [SV_W-1:0] sv_meta, sv_sync;
	logic          s_as_n, s_wr_n;
	logic [1:0]    s_ds_n;
	logic [5:0]    s_am, s_base;
	logic [23:1]   s_addr;
	logic [15:0]   s_data;
	logic [3:0]    s_err_n;
	logic          cycle, a16, a24, odd_only, carrier_hit, id_refuse;
	logic [1:0]    region, slot_a16, mem_slot;
	logic [7:0]    reg_off, reg_rdata;
	logic          reg_wr, reg_rd;
	logic [NSLOT-1:0] mem_hit;
	logic [3:0]    win_mask [NSLOT];
	logic          auto_clr_reg, aad_reg, tmo_reg, gie_reg;
	logic [2:0]    level_reg;
	logic [3:0]    memen_reg;
	logic [7:0]    win_reg [NSLOT];
	logic [7:0]    inten_reg;
	logic [7:0]    iclr_reg;
	logic [6:0]    srst_cnt_reg;

	// every pin input goes through two flops before any decode
	always_ff @(posedge clock)
		if (rst)
		begin
			// strobes reset to their idle levels so no cycle is seen
			sv_meta <= {4'hF, 1'h1, 2'h3, 1'h1, 51'h0};
			sv_sync <= {4'hF, 1'h1, 2'h3, 1'h1, 51'h0};
		end
		else if (ce)
		begin
			sv_meta <= {ip_error_n, vme_as_n, vme_ds_n, vme_write_n, vme_am,
				vme_addr, vme_data_i, board_base_sel};
			sv_sync <= sv_meta;
		end
	assign {s_err_n, s_as_n, s_ds_n, s_wr_n, s_am, s_addr, s_data, s_base} =
		sv_sync;

	assign cycle = !s_as_n && s_ds_n != 2'h3;
	assign a16 = (s_am == AM_A16_USR || s_am == AM_A16_SUP)
		&& s_addr[15:10] == s_base;
	assign a24 = s_am == AM_A24_USR || s_am == AM_A24_SUP;
	assign region = s_addr[7:6];
	assign slot_a16 = s_addr[9:8];
	assign odd_only = !s_ds_n[0] && s_ds_n[1];
	assign reg_off = {s_addr[7:1], 1'b1};
	assign carrier_hit = a16 && region == RG_CARRIER;
	// id space takes odd byte reads only; anything else is answered blank
	assign id_refuse = a16 && region == RG_ID && (!s_wr_n || !odd_only);
	assign reg_wr = state_reg == B_IDLE && cycle && carrier_hit
		&& slot_a16 == CARRIER_SLOT && !s_wr_n && !s_ds_n[0];
	assign reg_rd = state_reg == B_IDLE && cycle && carrier_hit
		&& slot_a16 == CARRIER_SLOT && s_wr_n && !s_ds_n[0];

	for (genvar i = 0; i < NSLOT; i++)
	begin : g_win
		assign win_mask[i] = 4'(MW_MASK_1MB << win_reg[i][MW_SIZE_HI:MW_SIZE_LO]);
		assign mem_hit[i] = a24 && memen_reg[i]
			&& ((s_addr[23:20] ^ win_reg[i][MW_BASE_HI:MW_BASE_LO])
			& win_mask[i]) == 4'h0;
		always_ff @(posedge clock)
			if (rst)
				win_reg[i] <= 8'h00;
			else if (ce && reg_wr && reg_off == OFF_WIN[i])
				win_reg[i] <= s_data[7:0];
	end

	// overlapping windows are a software error; lowest slot wins
	always_comb
	begin
		mem_slot = 2'h0;
		for (int i = NSLOT - 1; i >= 0; i--)
			if (mem_hit[i])
				mem_slot = 2'(i);
	end

	always_comb
	begin
		reg_rdata = 8'h00;
		unique case (reg_off)
			OFF_STATUS:
			begin
				reg_rdata[ST_AUTOCLR] = auto_clr_reg;
				reg_rdata[ST_AAD] = aad_reg;
				reg_rdata[ST_TMO] = tmo_reg;
				reg_rdata[ST_GIE] = gie_reg;
				reg_rdata[ST_GIP] = |link.pending;
			end
			OFF_LEVEL: reg_rdata = {5'h00, level_reg};
			OFF_ERROR: reg_rdata = {7'h00, ~&s_err_n};
			OFF_MEMEN: reg_rdata = {4'h0, memen_reg};
			OFF_INTEN: reg_rdata = inten_reg;
			OFF_PEND: reg_rdata = link.pending;
			default:
				for (int i = 0; i < NSLOT; i++)
					if (reg_off == OFF_WIN[i])
						reg_rdata = win_reg[i];
		endcase
	end

	always_ff @(posedge clock)
		if (rst)
		begin
			auto_clr_reg <= 1'b0;
			aad_reg <= 1'b0;
			gie_reg <= 1'b0;
			level_reg <= 3'h0;
			memen_reg <= 4'h0;
			inten_reg <= 8'h00;
			iclr_reg <= 8'h00;
		end
		else if (ce)
		begin
			iclr_reg <= 8'h00;
			if (reg_wr)
				unique case (reg_off)
					OFF_STATUS:
					begin
						auto_clr_reg <= s_data[ST_AUTOCLR];
						aad_reg <= s_data[ST_AAD];
						gie_reg <= s_data[ST_GIE];
					end
					OFF_LEVEL: level_reg <= s_data[2:0];
					OFF_MEMEN: memen_reg <= s_data[3:0];
					OFF_INTEN: inten_reg <= s_data[7:0];
					OFF_ICLR: iclr_reg <= s_data[7:0];
					default: ;
				endcase
		end

	// a timeout in the same cycle as a status read still sets the flag
	always_ff @(posedge clock)
		if (rst)
			tmo_reg <= 1'b0;
		else if (ce)
		begin
			if (link.done && link.timed_out)
				tmo_reg <= 1'b1;
			else if (reg_rd && reg_off == OFF_STATUS)
				tmo_reg <= 1'b0;
		end

	always_ff @(posedge clock)
		if (rst)
		begin
			srst_cnt_reg <= 7'h00;
			ip_reset_n <= 1'b0;
		end
		else if (ce)
		begin
			if (reg_wr && reg_off == OFF_STATUS && s_data[ST_SRST])
				srst_cnt_reg <= SRST_CYC;
			else if (srst_cnt_reg != 7'h00)
				srst_cnt_reg <= srst_cnt_reg - 7'h01;
			ip_reset_n <= srst_cnt_reg == 7'h00;
		end

	assign link.enable = inten_reg;
	assign link.clear = iclr_reg;
	assign link.global_irq_enable = gie_reg;
	assign link.auto_clear = auto_clr_reg;
	assign link.level = level_reg;
	assign link.soft_rst = srst_cnt_reg != 7'h00;

	always_ff @(posedge clock)
		if (rst)
		begin
			state_reg <= B_IDLE;
			vme_data_o <= 16'h0000;
			vme_data_oe <= 1'b0;
			vme_dtack_oe <= 1'b0;
			vme_berr_oe <= 1'b0;
			link.start <= 1'b0;
			link.kind <= IPCB_K_IO;
			link.slot <= 2'h0;
			link.write <= 1'b0;
			link.addr <= '0;
			link.wdata <= 16'h0000;
			link.lanes_n <= 2'h3;
		end
		else if (ce)
		begin
			link.start <= 1'b0;
			unique case (state_reg)
				B_IDLE:
					if (cycle && (carrier_hit || id_refuse))
					begin
						vme_data_o <= reg_rd ? {8'h00, reg_rdata} : 16'h0000;
						vme_data_oe <= s_wr_n;
						vme_dtack_oe <= 1'b1;
						state_reg <= B_ANS;
					end
					else if (cycle && (a16 || |mem_hit))
					begin
						link.start <= 1'b1;
						link.kind <= !a16 ? IPCB_K_MEM
							: (s_addr[7] ? IPCB_K_ID : IPCB_K_IO);
						link.slot <= a16 ? slot_a16 : mem_slot;
						link.write <= !s_wr_n;
						link.addr <= s_addr[22:1];
						link.wdata <= s_data;
						link.lanes_n <= s_ds_n;
						state_reg <= B_MOD;
					end
				B_MOD:
					if (link.done)
					begin
						vme_data_o <= link.rdata;
						if (link.timed_out && aad_reg)
							vme_berr_oe <= 1'b1;
						else
						begin
							vme_data_oe <= !link.write;
							vme_dtack_oe <= 1'b1;
						end
						state_reg <= B_ANS;
					end
				B_ANS:
					if (s_ds_n == 2'h3)
					begin
						vme_data_oe <= 1'b0;
						vme_dtack_oe <= 1'b0;
						vme_berr_oe <= 1'b0;
						state_reg <= B_IDLE;
					end
			endcase
		end

	ipcb_ipseq u_seq (
		.clock       (clock),
		.rst         (rst),
		.ce          (ce),
		.link        (link.seq),
		.ip_ack_n    (ip_ack_n),
		.ip_data_i   (ip_data_i),
		.ip_clk      (ip_clk),
		.ip_iosel_n  (ip_iosel_n),
		.ip_idsel_n  (ip_idsel_n),
		.ip_memsel_n (ip_memsel_n),
		.ip_rw_n     (ip_rw_n),
		.ip_addr     (ip_addr),
		.ip_bs_n     (ip_bs_n),
		.ip_data_o   (ip_data_o),
		.ip_data_oe  (ip_data_oe)
	);

	ipcb_irq u_irq (
		.clock       (clock),
		.rst         (rst),
		.ce          (ce),
		.link        (link.irq),
		.ip_intreq_n (ip_intreq_n),
		.vme_irq_oe  (vme_irq_oe)
	);

	a_tmo_clear_read: assert property (@(posedge clock) disable iff (rst)
		ce && reg_rd && reg_off == OFF_STATUS && !link.done |=> !tmo_reg)
		else $error("timeout flag survived status read");
	a_berr_aad: assert property (@(posedge clock) disable iff (rst)
		ce && state_reg == B_MOD && link.done && link.timed_out && aad_reg
		|=> vme_berr_oe && !vme_dtack_oe)
		else $error("no bus error on timeout");
	a_auto_ack: assert property (@(posedge clock) disable iff (rst)
		ce && state_reg == B_MOD && link.done && link.timed_out && !aad_reg
		|=> vme_dtack_oe && tmo_reg && !vme_berr_oe)
		else $error("timeout access not completed");
	a_srst_len: assert property (@(posedge clock) disable iff (rst)
		$fell(ip_reset_n) |-> !ip_reset_n [*8] ##43 ip_reset_n)
		else $error("soft reset pulse length wrong");
	a_mem_enable: assert property (@(posedge clock) disable iff (rst)
		link.start && link.kind == IPCB_K_MEM |-> memen_reg[link.slot])
		else $error("memory access to disabled slot");
	a_id_readonly: assert property (@(posedge clock) disable iff (rst)
		link.start && link.kind == IPCB_K_ID |-> !link.write
		&& link.lanes_n == 2'h2)
		else $error("id access not an odd byte read");
	a_no_foreign: assert property (@(posedge clock) disable iff (rst)
		ce && state_reg == B_IDLE && !a16 && mem_hit == 4'h0
		|=> !vme_dtack_oe && !link.start)
		else $error("answered an address outside the board");
	a_gip_read: assert property (@(posedge clock) disable iff (rst)
		ce && reg_rd && reg_off == OFF_STATUS |=> vme_data_o[ST_GIP]
		== $past(|link.pending) && vme_data_o[1:0] == 2'h0)
		else $error("global pending bit wrong");
	c_reg_write: cover property (@(posedge clock) disable iff (rst)
		reg_wr && reg_off == OFF_MEMEN);
	c_berr: cover property (@(posedge clock) disable iff (rst)
		$rose(vme_berr_oe));
	c_mem_access: cover property (@(posedge clock) disable iff (rst)
		link.start && link.kind == IPCB_K_MEM ##[1:200] vme_dtack_oe);
endmodule

/* hw/ipcb_pkg.sv */
package ipcb_pkg;
	localparam int CLK_MHZ = 50;
	localparam int IP_MHZ  = 8;
	// soft reset pulse length in ns, rounded up to whole clock cycles
	localparam int SRST_NS = 1000;
	localparam logic [6:0] SRST_CYC = 7'((SRST_NS * CLK_MHZ + 999) / 1000);
	// module clock made by a phase accumulator: toggles at twice its rate
	localparam logic [6:0] IP_PH_STEP = 7'(2 * IP_MHZ);
	localparam logic [6:0] IP_PH_MOD  = 7'(CLK_MHZ);
	// module clock periods before an unanswered access is ended
	localparam logic [3:0] TMO_IP_CYC = 4'h8;
	localparam int NSLOT = 4;
	localparam int NREQ  = 8;
	// address modifiers
	localparam logic [5:0] AM_A16_USR = 6'h29;
	localparam logic [5:0] AM_A16_SUP = 6'h2D;
	localparam logic [5:0] AM_A24_USR = 6'h39;
	localparam logic [5:0] AM_A24_SUP = 6'h3D;
	// short i/o block layout: addr[9:8] slot, addr[7:6] region
	localparam logic [1:0] RG_ID      = 2'h2;
	localparam logic [1:0] RG_CARRIER = 2'h3;
	localparam logic [1:0] CARRIER_SLOT = 2'h0;
	// carrier register byte offsets
	localparam logic [7:0] OFF_STATUS = 8'hC1;
	localparam logic [7:0] OFF_LEVEL  = 8'hC3;
	localparam logic [7:0] OFF_ERROR  = 8'hC5;
	localparam logic [7:0] OFF_MEMEN  = 8'hC7;
	localparam logic [7:0] OFF_WIN [NSLOT] = '{8'hD1, 8'hD3, 8'hD5, 8'hD7};
	localparam logic [7:0] OFF_INTEN  = 8'hE1;
	localparam logic [7:0] OFF_PEND   = 8'hE3;
	localparam logic [7:0] OFF_ICLR   = 8'hE5;
	// status field positions
	localparam int ST_AUTOCLR = 7;
	localparam int ST_AAD     = 6;
	localparam int ST_TMO     = 5;
	localparam int ST_SRST    = 4;
	localparam int ST_GIE     = 3;
	localparam int ST_GIP     = 2;
	// memory window fields
	localparam int MW_BASE_HI = 7;
	localparam int MW_BASE_LO = 4;
	localparam int MW_SIZE_HI = 3;
	localparam int MW_SIZE_LO = 2;
	localparam logic [3:0] MW_MASK_1MB = 4'hF;
	typedef enum logic [1:0] {IPCB_K_IO, IPCB_K_ID, IPCB_K_MEM} ipcb_kind_e;
endpackage

/* hw/ipcb_link_if.sv */
`timescale 1ns/1ps
interface ipcb_link_if;
	import ipcb_pkg::*;
	logic             start;
	ipcb_kind_e       kind;
	logic [1:0]       slot;
	logic             write;
	logic [22:1]      addr;
	logic [15:0]      wdata;
	logic [1:0]       lanes_n;
	logic             done;
	logic             timed_out;
	logic [15:0]      rdata;
	logic [NREQ-1:0]  enable;
	logic [NREQ-1:0]  clear;
	logic [NREQ-1:0]  pending;
	logic             global_irq_enable;
	logic             auto_clear;
	logic [2:0]       level;
	logic             soft_rst;
	modport top (output start, kind, slot, write, addr, wdata, lanes_n,
		enable, clear, global_irq_enable, auto_clear, level, soft_rst,
		input done, timed_out, rdata, pending);
	modport seq (input start, kind, slot, write, addr, wdata, lanes_n,
		output done, timed_out, rdata);
	modport irq (input enable, clear, global_irq_enable, auto_clear, level, soft_rst,
		output pending);
endinterface

/* hw/ipcb_ipseq.sv */
`timescale 1ns/1ps
module ipcb_ipseq
	import ipcb_pkg::*;
(
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        ce,
	ipcb_link_if.seq         link,
	input  wire logic        ip_ack_n,
	input  wire logic [15:0] ip_data_i,
	output logic             ip_clk,
	output logic [3:0]       ip_iosel_n,
	output logic [3:0]       ip_idsel_n,
	output logic [3:0]       ip_memsel_n,
	output logic             ip_rw_n,
	output logic [22:1]      ip_addr,
	output logic [1:0]       ip_bs_n,
	output logic [15:0]      ip_data_o,
	output logic             ip_data_oe
);
	typedef enum {Q_IDLE, Q_SEL, Q_WAIT} ipcb_q_e;
	ipcb_q_e     q_reg;
	logic [5:0]  phase_reg;
	logic [6:0]  phase_sum;
	logic        wrap;
	logic        fall;
	logic        ack_meta, ack_sync;
	logic [15:0] dat_meta, dat_sync;
	logic [3:0]  wait_reg;
	logic [3:0]  onehot;

	assign phase_sum = {1'b0, phase_reg} + IP_PH_STEP;
	assign wrap = phase_sum >= IP_PH_MOD;
	// act on the falling edge so selects settle before the module samples
	assign fall = wrap && ip_clk;
	assign onehot = 4'(4'h1 << link.slot);

	always_ff @(posedge clock)
		if (rst)
		begin
			phase_reg <= '0;
			ip_clk <= 1'b0;
		end
		else if (ce)
		begin
			phase_reg <= wrap ? 6'(phase_sum - IP_PH_MOD) : phase_sum[5:0];
			if (wrap)
				ip_clk <= ~ip_clk;
		end

	always_ff @(posedge clock)
		if (rst)
		begin
			ack_meta <= 1'b1;
			ack_sync <= 1'b1;
			dat_meta <= '0;
			dat_sync <= '0;
		end
		else if (ce)
		begin
			ack_meta <= ip_ack_n;
			ack_sync <= ack_meta;
			dat_meta <= ip_data_i;
			dat_sync <= dat_meta;
		end

	always_ff @(posedge clock)
		if (rst)
		begin
			q_reg <= Q_IDLE;
			wait_reg <= '0;
			link.done <= 1'b0;
			link.timed_out <= 1'b0;
			link.rdata <= '0;
			ip_iosel_n <= 4'hF;
			ip_idsel_n <= 4'hF;
			ip_memsel_n <= 4'hF;
			ip_rw_n <= 1'b1;
			ip_addr <= '0;
			ip_bs_n <= 2'h3;
			ip_data_o <= '0;
			ip_data_oe <= 1'b0;
		end
		else if (ce)
		begin
			link.done <= 1'b0;
			unique case (q_reg)
				Q_IDLE:
					if (link.start)
						q_reg <= Q_SEL;
				Q_SEL:
					if (fall)
					begin
						ip_iosel_n <= (link.kind == IPCB_K_IO) ? ~onehot : 4'hF;
						ip_idsel_n <= (link.kind == IPCB_K_ID) ? ~onehot : 4'hF;
						ip_memsel_n <= (link.kind == IPCB_K_MEM) ? ~onehot : 4'hF;
						ip_rw_n <= ~link.write;
						ip_addr <= link.addr;
						ip_bs_n <= link.lanes_n;
						ip_data_o <= link.wdata;
						ip_data_oe <= link.write;
						wait_reg <= '0;
						q_reg <= Q_WAIT;
					end
				Q_WAIT:
					if (fall)
					begin
						// each module wait state costs one more module period
						if (!ack_sync || wait_reg == TMO_IP_CYC)
						begin
							link.rdata <= dat_sync;
							link.timed_out <= ack_sync;
							link.done <= 1'b1;
							ip_iosel_n <= 4'hF;
							ip_idsel_n <= 4'hF;
							ip_memsel_n <= 4'hF;
							ip_rw_n <= 1'b1;
							ip_bs_n <= 2'h3;
							ip_data_oe <= 1'b0;
							q_reg <= Q_IDLE;
						end
						else
							wait_reg <= wait_reg + 4'h1;
					end
			endcase
		end

	a_tmo_bounded: assert property (@(posedge clock) disable iff (rst)
		link.start |-> ##[1:200] link.done)
		else $error("module access not ended in time");
endmodule

/* hw/ipcb_irq.sv */
`timescale 1ns/1ps
module ipcb_irq
	import ipcb_pkg::*;
(
	input  wire logic            clock,
	input  wire logic            rst,
	input  wire logic            ce,
	ipcb_link_if.irq             link,
	input  wire logic [NREQ-1:0] ip_intreq_n,
	output logic [7:1]           vme_irq_oe
);
	logic [NREQ-1:0] req_meta, req_sync, pend_reg;
	logic            active;

	assign link.pending = pend_reg;
	assign active = link.global_irq_enable && |(pend_reg & link.enable);

	always_ff @(posedge clock)
		if (rst)
		begin
			req_meta <= '0;
			req_sync <= '0;
		end
		else if (ce)
		begin
			req_meta <= ~ip_intreq_n;
			req_sync <= req_meta;
		end

	always_ff @(posedge clock)
		if (rst)
			pend_reg <= '0;
		else if (ce)
		begin
			if (link.soft_rst)
				pend_reg <= '0;
			else if (link.auto_clear)
				pend_reg <= req_sync;
			else
				pend_reg <= (pend_reg & ~link.clear) | req_sync;
		end

	// only module requests are passed on; nothing originates here
	for (genvar l = 1; l <= 7; l++)
	begin : g_lvl
		always_ff @(posedge clock)
			if (rst)
				vme_irq_oe[l] <= 1'b0;
			else if (ce)
				vme_irq_oe[l] <= active && link.level == 3'(l);
	end

	a_irq_gated: assert property (@(posedge clock) disable iff (rst)
		ce && !link.global_irq_enable |=> vme_irq_oe == 7'h00)
		else $error("interrupt passed with global enable off");
	a_pend_follow: assert property (@(posedge clock) disable iff (rst)
		ce && link.auto_clear && !link.soft_rst |=> pend_reg == $past(req_sync))
		else $error("pending latched in auto clear mode");
	a_irq_level: assert property (@(posedge clock) disable iff (rst)
		ce && active && link.level == 3'h3 |=> vme_irq_oe == 7'h04)
		else $error("request not on chosen level");
	c_irq_out: cover property (@(posedge clock) disable iff (rst)
		$rose(|vme_irq_oe));
endmodule

/* verification/ipcb_ip_model.sv */
`timescale 1ns/1ps
module ipcb_ip_model
	import ipcb_pkg::*;
#(
	parameter int         WAITS   = 2,
	parameter logic [3:0] PRESENT = 4'h1,
	parameter logic [7:0] MODEL   = 8'h3C // arbitrary model code
)
(
	input  wire logic [3:0] sel_n,
	input  wire logic       ip_clk,
	input  wire logic [6:1] addr,
	output logic            ip_ack_n,
	output logic [15:0]     ip_data_i
);
	int   cnt = 0;
	logic hit;
	assign hit = |(~sel_n & PRESENT);
	initial ip_ack_n = 1'h1;
	initial ip_data_i = 16'h0000;
	// empty slots never answer; idle data toggles so stale values never match
	always @(posedge ip_clk)
	begin
		if (hit && cnt == WAITS)
		begin
			ip_ack_n <= 1'h0;
			ip_data_i <= {8'h00, (addr == 6'h05) ? MODEL : 8'h5A};
		end
		else
		begin
			ip_ack_n <= 1'h1;
			ip_data_i <= ~ip_data_i;
		end
		cnt <= hit ? cnt + 1 : 0;
	end
endmodule

/* verification/ipcb_bridge_test.sv */
`timescale 1ns/1ps
module ipcb_bridge_test;
	import ipcb_pkg::*;
	localparam logic [5:0] BASE = 6'h15;
	typedef struct packed {
		logic       w;
		logic [7:0] off;
		logic [1:0] ds;
		logic [7:0] d;
	} ipcb_row_s;
	logic            clock;
	logic            rst = 1'h1, ce = 1'h1;
	logic            vme_as_n = 1'h1, vme_write_n = 1'h1;
	logic [1:0]      vme_ds_n = 2'h3;
	logic [5:0]      vme_am = 6'h00, board_base_sel = BASE;
	logic [23:1]     vme_addr = 23'h0;
	logic [15:0]     vme_data_i = 16'h0000, vme_data_o, ip_data_i, ip_data_o;
	logic            vme_data_oe, vme_dtack_oe, vme_berr_oe, ip_clk;
	logic [7:1]      vme_irq_oe;
	logic            ip_reset_n, ip_rw_n, ip_data_oe, ip_ack_n;
	logic [3:0]      ip_iosel_n, ip_idsel_n, ip_memsel_n;
	logic [22:1]     ip_addr;
	logic [1:0]      ip_bs_n, resp;
	logic [NREQ-1:0] ip_intreq_n = 8'hFF;
	logic [3:0]      ip_error_n = 4'hD;
	logic [15:0]     rdat;
	int              miscompares = 0, n_checks = 0, low_n = 0;
	ipcb_row_s rows[18] = '{
		'{1'h0, 8'hC1, 2'h2, 8'h00}, '{1'h0, 8'hC7, 2'h2, 8'h00},
		'{1'h0, 8'hE3, 2'h2, 8'h00}, '{1'h0, 8'hC5, 2'h2, 8'h01},
		'{1'h1, 8'hC7, 2'h2, 8'hFF}, '{1'h0, 8'hC7, 2'h2, 8'h0F},
		'{1'h1, 8'hD1, 2'h2, 8'hA8}, '{1'h0, 8'hD1, 2'h2, 8'hA8},
		'{1'h1, 8'hD7, 2'h2, 8'hF4}, '{1'h0, 8'hD7, 2'h2, 8'hF4},
		'{1'h1, 8'hC3, 2'h2, 8'h03}, '{1'h0, 8'hC3, 2'h2, 8'h03},
		'{1'h1, 8'hE1, 2'h2, 8'h01}, '{1'h0, 8'hE1, 2'h2, 8'h01},
		'{1'h0, 8'hC0, 2'h1, 8'h00}, '{1'h1, 8'hC9, 2'h2, 8'hFF},
		'{1'h0, 8'hC9, 2'h2, 8'h00}, '{1'h1, 8'hC1, 2'h2, 8'h08}};

	ipcb_bridge uut (
		.clock          (clock),
		.rst            (rst),
		.ce             (ce),
		.vme_as_n       (vme_as_n),
		.vme_ds_n       (vme_ds_n),
		.vme_write_n    (vme_write_n),
		.vme_am         (vme_am),
		.vme_addr       (vme_addr),
		.vme_data_i     (vme_data_i),
		.vme_data_o     (vme_data_o),
		.vme_data_oe    (vme_data_oe),
		.vme_dtack_oe   (vme_dtack_oe),
		.vme_berr_oe    (vme_berr_oe),
		.vme_irq_oe     (vme_irq_oe),
		.board_base_sel (board_base_sel),
		.ip_clk         (ip_clk),
		.ip_reset_n     (ip_reset_n),
		.ip_iosel_n     (ip_iosel_n),
		.ip_idsel_n     (ip_idsel_n),
		.ip_memsel_n    (ip_memsel_n),
		.ip_rw_n        (ip_rw_n),
		.ip_addr        (ip_addr),
		.ip_bs_n        (ip_bs_n),
		.ip_data_i      (ip_data_i),
		.ip_data_o      (ip_data_o),
		.ip_data_oe     (ip_data_oe),
		.ip_ack_n       (ip_ack_n),
		.ip_intreq_n    (ip_intreq_n),
		.ip_error_n     (ip_error_n)
	);
	ipcb_ip_model mdl (
		.sel_n    (ip_iosel_n & ip_idsel_n & ip_memsel_n),
		.ip_clk   (ip_clk),
		.addr     (ip_addr[6:1]),
		.ip_ack_n (ip_ack_n),
		.ip_data_i(ip_data_i)
	);

	initial
	begin
		clock = 1'h0;
		forever #10 clock = ~clock;
	end

	always @(posedge clock)
		if (ip_reset_n === 1'h0)
			low_n++;

	function automatic logic [23:1] a16(input logic [9:0] o);
		return {8'h00, BASE, o[9:1]};
	endfunction

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		n_checks++;
		if (g !== e)
		begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask

	// strobes held until an answer or 400 cycles, then released together
	task automatic xfer(input logic w, input logic [5:0] m,
		input logic [23:1] a, input logic [1:0] d, input logic [15:0] wd);
		int n;
		logic [1:0] q;
		@(posedge clock);
		vme_am <= m;
		vme_addr <= a;
		vme_write_n <= ~w;
		vme_data_i <= wd;
		vme_as_n <= 1'h0;
		vme_ds_n <= d;
		resp = 2'h0;
		for (n = 0; n < 400 && resp === 2'h0; n++)
		begin
			@(posedge clock);
			resp = {vme_berr_oe, vme_dtack_oe};
			rdat = vme_data_o;
		end
		vme_as_n <= 1'h1;
		vme_ds_n <= 2'h3;
		// resp keeps the answer; q only waits for the release
		q = resp;
		for (n = 0; n < 9 && q !== 2'h0; n++)
		begin
			@(posedge clock);
			q = {vme_berr_oe, vme_dtack_oe};
		end
	endtask

	task automatic reg8(input logic w, input logic [7:0] o,
		input logic [1:0] d, input logic [7:0] v);
		xfer(w, AM_A16_SUP, a16({2'h0, o}), d, {8'h00, v});
		chk({14'h0, resp}, 16'h0001);
		if (!w)
			chk(rdat, {8'h00, v});
	endtask

	task automatic mod_rd(input logic [5:0] m, input logic [23:1] a,
		input logic [1:0] r, input logic [15:0] e);
		xfer(1'h0, m, a, 2'h0, 16'h0000);
		chk({14'h0, resp}, {14'h0, r});
		if (r == 2'h1)
			chk(rdat, e);
	endtask

	task automatic irq_is(input logic [7:0] req, input logic [7:1] e);
		ip_intreq_n <= req;
		repeat (8) @(posedge clock);
		chk({9'h0, vme_irq_oe}, {9'h0, e});
	endtask

	task automatic report_and_stop;
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (60000) @(posedge clock);
		miscompares++;
		report_and_stop();
	end

	initial
	begin
		repeat (12) @(posedge clock);
		rst <= 1'h0;
		foreach (rows[i])
			reg8(rows[i].w, rows[i].off, rows[i].ds, rows[i].d);
		mod_rd(AM_A16_USR, a16(10'h004), 2'h1, 16'h005A);
		xfer(1'h1, AM_A16_USR, a16(10'h006), 2'h0, 16'h1234);
		chk({14'h0, resp}, 16'h0001);
		chk(ip_data_o, 16'h1234);
		chk(16'(ip_addr[9:1]), 16'h0003);
		xfer(1'h0, AM_A16_USR, a16(10'h08B), 2'h2, 16'h0000);
		chk({14'h0, resp}, 16'h0001);
		chk(rdat, 16'h003C);
		xfer(1'h1, AM_A16_USR, a16(10'h08B), 2'h2, 16'h0011);
		chk({14'h0, resp}, 16'h0001);
		xfer(1'h0, AM_A16_USR, a16(10'h300), 2'h0, 16'h0000);
		chk({14'h0, resp}, 16'h0001);
		chk({12'h0, ip_iosel_n}, 16'h000F);
		reg8(1'h0, 8'hC1, 2'h2, 8'h28);
		reg8(1'h0, 8'hC1, 2'h2, 8'h08);
		reg8(1'h1, 8'hC1, 2'h2, 8'h48);
		mod_rd(AM_A16_USR, a16(10'h300), 2'h2, 16'h0000);
		reg8(1'h1, 8'hC1, 2'h2, 8'h08);
		xfer(1'h0, AM_A16_SUP, a16(10'h0C1), 2'h2, 16'h0000);
		irq_is(8'hFE, 7'h04);
		reg8(1'h0, 8'hE3, 2'h2, 8'h01);
		reg8(1'h0, 8'hC1, 2'h2, 8'h0C);
		irq_is(8'hFF, 7'h04);
		reg8(1'h1, 8'hE5, 2'h2, 8'h01);
		reg8(1'h0, 8'hE3, 2'h2, 8'h00);
		reg8(1'h1, 8'hC1, 2'h2, 8'h00);
		irq_is(8'hFE, 7'h00);
		reg8(1'h0, 8'hC1, 2'h2, 8'h04);
		reg8(1'h1, 8'hC1, 2'h2, 8'h80);
		irq_is(8'hFF, 7'h00);
		reg8(1'h0, 8'hE3, 2'h2, 8'h00);
		reg8(1'h1, 8'hE1, 2'h2, 8'h00);
		reg8(1'h1, 8'hC1, 2'h2, 8'h08);
		irq_is(8'hFE, 7'h00);
		low_n = 0;
		reg8(1'h1, 8'hC1, 2'h2, 8'h18);
		repeat (80) @(posedge clock);
		chk(16'(low_n), 16'(SRST_CYC));
		reg8(1'h0, 8'hC1, 2'h2, 8'h0C);
		reg8(1'h1, 8'hD1, 2'h2, 8'h10);
		reg8(1'h1, 8'hC7, 2'h2, 8'h00);
		mod_rd(AM_A24_SUP, {4'h1, 19'h10}, 2'h0, 16'h0000);
		reg8(1'h1, 8'hC7, 2'h2, 8'h01);
		mod_rd(AM_A24_USR, {4'h1, 19'h10}, 2'h1, 16'h005A);
		mod_rd(AM_A16_SUP, {8'h00, ~BASE, 9'h061}, 2'h0, 16'h0000);
		mod_rd(6'h09, a16(10'h0C1), 2'h0, 16'h0000);
		report_and_stop();
	end
endmodule
